// ===== hall_dsp_defs.svh
`ifndef HALL_DSP_DEFS_SVH
`define HALL_DSP_DEFS_SVH

// Register indices of the serial command map
`define ADDR_FIELD_CONFIG 4'h0
`define ADDR_LIN_TC 4'h1
`define ADDR_QUAD_TC 4'h2
`define ADDR_GAIN 4'h3
`define ADDR_ZERO_LEVEL 4'h4
`define ADDR_CLAMP_LOW 4'h5
`define ADDR_CLAMP_HIGH 4'h6
`define ADDR_FREEZE 4'h7
`define ADDR_RAW 4'h8
`define ADDR_TRIM_OSC 4'h9
`define ADDR_TRIM_ADC 4'hA
`define ADDR_TRIM_SPECIAL 4'hB

// Field positions inside field_config
`define SPAN_LSB 0
`define SPAN_MSB 2
`define CUTOFF_LSB 3
`define CUTOFF_MSB 5

// Reset values of the configuration store
`define RST_FIELD_CONFIG 6'h00
`define RST_LIN_TC 10'h000
`define RST_QUAD_TC 8'h00
`define RST_GAIN 14'h0800
`define RST_ZERO_LEVEL 11'h200
`define RST_CLAMP_LOW 10'h000
`define RST_CLAMP_HIGH 11'h7FF
`define RST_TRIM 8'h00

// Telegram geometry and timing
`define ADDR_BITS 5'h04
`define HEAD_BITS 5'h05
`define DATA_BITS 5'h0E
`define REPLY_BITS 5'h0E
`define REPLY_BIT_CYCLES 4'h1

// Gain of one in register units, as a shift
`define GAIN_FRAC 11

// Raw readout limits per cutoff code
`define RAW_LIM_80HZ 14'h0F7F
`define RAW_LIM_160HZ 14'h07C1
`define RAW_LIM_500HZ 14'h14AA
`define RAW_LIM_1KHZ 14'h0A55
`define RAW_LIM_2KHZ 14'h05E7

// Magnitudes of the negative raw readout limits per cutoff code
`define RAW_LO_80HZ 14'h0F80
`define RAW_LO_160HZ 14'h07C1
`define RAW_LO_500HZ 14'h14AC
`define RAW_LO_1KHZ 14'h0A56
`define RAW_LO_2KHZ 14'h05E8

`endif

// ===== hall_dsp_pkg.sv
package hall_dsp_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_HEAD,
      ST_DATA,
      ST_EXEC,
      ST_REPLY
   } xchg_state_t;

endpackage : hall_dsp_pkg

// ===== sample_fifo.sv
`timescale 1ns/1ps

module sample_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 32
)(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_wr_valid,
   input wire logic [WIDTH-1:0] i_wr_data,
   output logic o_wr_ready,
   output logic o_rd_valid,
   output logic [WIDTH-1:0] o_rd_data,
   input wire logic i_rd_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0] count_q;
   wire push = i_wr_valid && o_wr_ready;
   wire pop = o_rd_valid && i_rd_ready;

   assign o_wr_ready = (count_q != (AW+1)'(DEPTH));
   assign o_rd_valid = (count_q != '0);
   assign o_rd_data = mem_q[rd_ptr_q];

   // Storage carries no reset; empty flag guards stale words
   always_ff @(posedge i_sys_clk)
   begin
      if (push)
         mem_q[wr_ptr_q] <= i_wr_data;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
         if (pop)
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
         if (push && !pop)
            count_q <= count_q + 1'b1;
         else if (pop && !push)
            count_q <= count_q - 1'b1;
      end
   end

endmodule : sample_fifo

// ===== hall_dsp_config_path.sv
`timescale 1ns/1ps
`include "hall_dsp_defs.svh"

// Notes on behaviour
// [RULE1] Once frozen, no register is ever written again; freeze clears only on reset.
// [RULE2] Unfrozen, the programmer rewrites the output characteristic via supply telegrams.
// [RULE3] A valid telegram is executed, then answered serially on the response pin.
// [RULE4] Analog output is off for the whole command exchange.
// [RULE5] Only a device selected through its own output pin takes telegrams.
// [RULE6] Trim registers are writable only in production mode, read-only otherwise.
// [RULE7] Converter value is signed: positive north pole, negative south pole.
// [RULE8] Converter value is low-pass filtered and readable as raw_field_value.
// [RULE9] Output is raw times gain, plus zero level, clamped between limits; the code adds twice zero_level_q.
// [RULE10] Zero raw value yields exactly the programmed zero level; the code gives twice zero_level_q.
// [RULE11] Raw value limits depend on the selected filter cutoff.
// [RULE12] Span code is field_config bits 2:0, driven to the converter.
// [RULE13] Cutoff code is field_config bits 5:3, codes 0 to 4.
// [RULE14] Gain is signed, -4 to 4, one step is 1/2048.
// [RULE15] Gain of one adds full supply per 2048 raw counts.
// [RULE16] Linear and quadratic coefficients drive sensitivity temperature scaling.
// [RULE17] Every path parameter comes from the configuration registers.
// [RULE18] raw_field_value is a 14-bit readable register before gain and clamping.
// [RULE19] Frozen device ignores all supply telegrams, reads included.
// [RULE20] Out-of-range results saturate at the nearest clamp, never wrap.
module hall_dsp_config_path #(
   parameter int RAW_W = 14,
   parameter int FIFO_DEPTH = 32
)(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_adc_valid,
   input wire logic signed [RAW_W-1:0] i_adc_data,
   output logic o_adc_ready,
   input wire logic i_dac_ready,
   output logic o_dac_valid,
   output logic [10:0] o_dac_level,
   output logic o_analog_en,
   input wire logic i_prog_valid,
   input wire logic i_prog_bit,
   input wire logic i_out_select,
   input wire logic i_factory_mode,
   output logic o_resp_bit,
   output logic o_resp_oe_n,
   output logic [2:0] o_span_select,
   output logic [9:0] o_lin_tc,
   output logic [7:0] o_quad_tc,
   output logic [23:0] o_trim,
   output logic o_frozen
);
   // Six fraction bits keep the filter from stalling on small errors
   localparam int ACC_W = RAW_W + 6;

   hall_dsp_pkg::xchg_state_t state_q;
   hall_dsp_pkg::xchg_state_t state_d;

   logic [5:0] field_config_q;
   logic [9:0] lin_tc_q;
   logic [7:0] quad_tc_q;
   logic signed [13:0] gain_q;
   logic signed [10:0] zero_level_q;
   logic [9:0] clamp_low_q;
   logic [10:0] clamp_high_q;
   logic freeze_q;
   logic [7:0] trim_q [3];
   logic signed [RAW_W-1:0] raw_q;
   logic signed [ACC_W-1:0] acc_q;
   logic take_q;
   logic take_late_q;
   logic dac_valid_q;
   logic [10:0] dac_level_q;

   logic [4:0] head_q;
   logic [13:0] data_q;
   logic [4:0] bit_cnt_q;
   logic [13:0] reply_q;
   logic [3:0] tick_q;

   // Converter samples pass through a FIFO so the drain may stall
   wire fifo_valid;
   wire signed [RAW_W-1:0] fifo_data;
   wire take = fifo_valid && i_dac_ready;

   sample_fifo #(
      .WIDTH(RAW_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_wr_valid(i_adc_valid),
      .i_wr_data(i_adc_data),
      .o_wr_ready(o_adc_ready),
      .o_rd_valid(fifo_valid),
      .o_rd_data(fifo_data),
      .i_rd_ready(take)
   );

   // First-order low-pass; a larger shift gives a lower cutoff
   wire [2:0] cutoff = field_config_q[`CUTOFF_MSB:`CUTOFF_LSB]; // [RULE13]
   wire [2:0] lp_shift = (cutoff > 3'h4) ? 3'h2 : 3'h6 - cutoff;
   // Sample sign is kept as delivered: north positive, south negative [RULE7]
   wire signed [ACC_W-1:0] x_ext = {fifo_data, 6'h00};
   wire signed [ACC_W-1:0] lp_err = x_ext - acc_q;
   wire signed [ACC_W-1:0] acc_d = acc_q + (lp_err >>> lp_shift); // [RULE8]

   // Codes above 4 are undefined and behave like the widest cutoff
   wire [13:0] raw_lim =
      (cutoff == 3'h0) ? `RAW_LIM_80HZ :
      (cutoff == 3'h1) ? `RAW_LIM_160HZ :
      (cutoff == 3'h2) ? `RAW_LIM_500HZ :
      (cutoff == 3'h3) ? `RAW_LIM_1KHZ : `RAW_LIM_2KHZ;
   // Negative limits mirror the positive ones only at the 160 Hz cutoff
   wire [13:0] raw_lo_mag =
      (cutoff == 3'h0) ? `RAW_LO_80HZ :
      (cutoff == 3'h1) ? `RAW_LO_160HZ :
      (cutoff == 3'h2) ? `RAW_LO_500HZ :
      (cutoff == 3'h3) ? `RAW_LO_1KHZ : `RAW_LO_2KHZ;
   wire signed [RAW_W-1:0] lim_hi = RAW_W'(raw_lim);
   wire signed [RAW_W-1:0] lim_lo = -(RAW_W'(raw_lo_mag));
   wire signed [ACC_W-7:0] acc_int = acc_q[ACC_W-1:6];
   wire signed [RAW_W-1:0] raw_d =
      (acc_int > lim_hi) ? lim_hi :
      (acc_int < lim_lo) ? lim_lo : acc_int; // [RULE11]

   // Gain in 1/2048 units; 2048 raw counts at unity give 2048 DAC codes
   wire signed [27:0] product = raw_q * gain_q; // [RULE14]
   wire signed [16:0] scaled = product[27:`GAIN_FRAC]; // [RULE15]
   // Zero level steps are twice the DAC step
   wire signed [17:0] zero_ext = {{6{zero_level_q[10]}}, zero_level_q, 1'b0};
   // Wide sum cannot wrap, so the clamp below saturates cleanly
   wire signed [17:0] sum = {scaled[16], scaled} + zero_ext; // [RULE9] [RULE10]
   wire signed [17:0] lo_ext = {8'h00, clamp_low_q};
   wire signed [17:0] hi_ext = {7'h00, clamp_high_q};
   wire [10:0] out_level =
      (sum < lo_ext) ? {1'b0, clamp_low_q} :
      (sum > hi_ext) ? clamp_high_q : sum[10:0]; // [RULE20]

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         acc_q <= '0;
         raw_q <= '0;
         take_q <= 1'b0;
         take_late_q <= 1'b0;
      end
      else
      begin
         take_q <= take;
         take_late_q <= take_q;
         if (take)
            acc_q <= acc_d;
         raw_q <= raw_d; // [RULE18]
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         dac_level_q <= 11'h000;
         dac_valid_q <= 1'b0;
      end
      else
      begin
         // Waits for this sample's readout, so level and pulse never lag a sample
         if (take_late_q)
            dac_level_q <= out_level;
         dac_valid_q <= take_late_q;
      end
   end

   // Telegram: R/W bit, 4 address bits, then 14 data bits on writes
   wire selected = i_out_select && !freeze_q; // [RULE5] [RULE19]
   wire bit_in = i_prog_valid && selected;
   wire is_write = head_q[4];
   wire [3:0] addr = head_q[3:0];
   wire exec_wr = (state_q == hall_dsp_pkg::ST_EXEC) && is_write && !freeze_q; // [RULE1]
   wire trim_wr = exec_wr && i_factory_mode; // [RULE6]
   // A partial telegram waits with no timeout; the programmer must finish it
   wire tick_done = (tick_q == `REPLY_BIT_CYCLES - 4'h1);
   wire reply_last = tick_done && (bit_cnt_q == `REPLY_BITS - 5'h01);

   // Unmapped addresses read as zero but are still answered
   wire [13:0] rd_data =
      (addr == `ADDR_FIELD_CONFIG) ? {8'h00, field_config_q} :
      (addr == `ADDR_LIN_TC) ? {4'h0, lin_tc_q} :
      (addr == `ADDR_QUAD_TC) ? {6'h00, quad_tc_q} :
      (addr == `ADDR_GAIN) ? gain_q :
      (addr == `ADDR_ZERO_LEVEL) ? {3'h0, zero_level_q} :
      (addr == `ADDR_CLAMP_LOW) ? {4'h0, clamp_low_q} :
      (addr == `ADDR_CLAMP_HIGH) ? {3'h0, clamp_high_q} :
      (addr == `ADDR_FREEZE) ? {13'h0000, freeze_q} :
      (addr == `ADDR_RAW) ? 14'(raw_q) :
      (addr == `ADDR_TRIM_OSC) ? {6'h00, trim_q[0]} :
      (addr == `ADDR_TRIM_ADC) ? {6'h00, trim_q[1]} :
      (addr == `ADDR_TRIM_SPECIAL) ? {6'h00, trim_q[2]} : 14'h0000;

   // Bits arriving during execute or reply are dropped, not queued
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         hall_dsp_pkg::ST_IDLE:
            if (bit_in)
               state_d = hall_dsp_pkg::ST_HEAD;
         hall_dsp_pkg::ST_HEAD:
            if (bit_in && bit_cnt_q == `ADDR_BITS - 5'h01)
               state_d = head_q[3] ? hall_dsp_pkg::ST_DATA : hall_dsp_pkg::ST_EXEC;
         hall_dsp_pkg::ST_DATA:
            if (bit_in && bit_cnt_q == `DATA_BITS - 5'h01)
               state_d = hall_dsp_pkg::ST_EXEC;
         hall_dsp_pkg::ST_EXEC:
            state_d = hall_dsp_pkg::ST_REPLY; // [RULE3]
         hall_dsp_pkg::ST_REPLY:
            if (reply_last)
               state_d = hall_dsp_pkg::ST_IDLE;
      endcase
   end

   // First bit in IDLE is the R/W bit; HEAD counts the address bits
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_q <= hall_dsp_pkg::ST_IDLE;
         head_q <= 5'h00;
         data_q <= 14'h0000;
         bit_cnt_q <= 5'h00;
      end
      else
      begin
         state_q <= state_d;
         if (bit_in && (state_q == hall_dsp_pkg::ST_IDLE || state_q == hall_dsp_pkg::ST_HEAD))
            head_q <= {head_q[3:0], i_prog_bit};
         if (bit_in && state_q == hall_dsp_pkg::ST_DATA)
            data_q <= {data_q[12:0], i_prog_bit};
         if (state_d != state_q)
            bit_cnt_q <= 5'h00;
         else if (bit_in || (state_q == hall_dsp_pkg::ST_REPLY && tick_done))
            bit_cnt_q <= bit_cnt_q + 5'h01;
      end
   end

   // Reply shifts out MSB first; writes echo the received data word
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         reply_q <= 14'h0000;
         tick_q <= 4'h0;
      end
      else
      begin
         if (state_q == hall_dsp_pkg::ST_EXEC)
            reply_q <= is_write ? data_q : rd_data;
         else if (state_q == hall_dsp_pkg::ST_REPLY && tick_done)
            reply_q <= {reply_q[12:0], 1'b0};
         if (state_q != hall_dsp_pkg::ST_REPLY || tick_done)
            tick_q <= 4'h0;
         else
            tick_q <= tick_q + 4'h1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         field_config_q <= `RST_FIELD_CONFIG;
         lin_tc_q <= `RST_LIN_TC;
         quad_tc_q <= `RST_QUAD_TC;
         gain_q <= `RST_GAIN;
         zero_level_q <= `RST_ZERO_LEVEL;
         clamp_low_q <= `RST_CLAMP_LOW;
         clamp_high_q <= `RST_CLAMP_HIGH;
      end
      else if (exec_wr)
      begin
         if (addr == `ADDR_FIELD_CONFIG)
            field_config_q <= data_q[5:0]; // [RULE2]
         if (addr == `ADDR_LIN_TC)
            lin_tc_q <= data_q[9:0];
         if (addr == `ADDR_QUAD_TC)
            quad_tc_q <= data_q[7:0];
         if (addr == `ADDR_GAIN)
            gain_q <= data_q;
         if (addr == `ADDR_ZERO_LEVEL)
            zero_level_q <= data_q[10:0];
         if (addr == `ADDR_CLAMP_LOW)
            clamp_low_q <= data_q[9:0];
         if (addr == `ADDR_CLAMP_HIGH)
            clamp_high_q <= data_q[10:0];
      end
   end

   // Freeze is one-way for telegrams: only ever set, and only reset clears it
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         freeze_q <= 1'b0;
      else if (exec_wr && addr == `ADDR_FREEZE && data_q[0])
         freeze_q <= 1'b1; // [RULE1]
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         trim_q[0] <= `RST_TRIM;
         trim_q[1] <= `RST_TRIM;
         trim_q[2] <= `RST_TRIM;
      end
      else if (trim_wr)
      begin
         if (addr == `ADDR_TRIM_OSC)
            trim_q[0] <= data_q[7:0]; // [RULE6]
         if (addr == `ADDR_TRIM_ADC)
            trim_q[1] <= data_q[7:0];
         if (addr == `ADDR_TRIM_SPECIAL)
            trim_q[2] <= data_q[7:0];
      end
   end

   // Analog output drops as soon as the first telegram bit is taken
   assign o_analog_en = (state_q == hall_dsp_pkg::ST_IDLE); // [RULE4]
   assign o_resp_oe_n = (state_q != hall_dsp_pkg::ST_REPLY);
   // Fourteen shifts drain the reply register, so it reads zero outside a reply
   assign o_resp_bit = reply_q[13];
   assign o_dac_valid = dac_valid_q;
   assign o_dac_level = dac_level_q;
   // Analog front end takes these straight from the store [RULE17]
   assign o_span_select = field_config_q[`SPAN_MSB:`SPAN_LSB]; // [RULE12]
   assign o_lin_tc = lin_tc_q; // [RULE16]
   assign o_quad_tc = quad_tc_q;
   assign o_trim = {trim_q[2], trim_q[1], trim_q[0]};
   assign o_frozen = freeze_q;

endmodule : hall_dsp_config_path

// ===== hall_dsp_config_path_properties.sv
`timescale 1ns/1ps
module hall_dsp_config_path_properties (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_prog_valid,
   input wire logic i_out_select,
   input wire logic i_factory_mode,
   input wire logic o_adc_ready,
   input wire logic [10:0] o_dac_level,
   input wire logic o_dac_valid,
   input wire logic o_analog_en,
   input wire logic o_resp_oe_n,
   input wire logic [2:0] o_span_select,
   input wire logic [9:0] o_lin_tc,
   input wire logic [7:0] o_quad_tc,
   input wire logic [23:0] o_trim,
   input wire logic o_frozen
);
   logic [4:0] low_cnt_q;
   logic [4:0] low_cnt_d;
   // Reply length is 14, beyond what a repetition may unroll
   assign low_cnt_d = o_resp_oe_n ? 5'h00 : low_cnt_q + 5'h01;
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         low_cnt_q <= 5'h00;
      else
         low_cnt_q <= low_cnt_d;
   end
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   property p_freeze_sticky; o_frozen |=> o_frozen; endproperty
   a_freeze_sticky: assert property (p_freeze_sticky)
      else $error("freeze bit cleared");
   property p_frozen_deaf; o_frozen && o_analog_en |=> o_analog_en; endproperty
   a_frozen_deaf: assert property (p_frozen_deaf)
      else $error("frozen device started an exchange");
   property p_reply_silent; !o_resp_oe_n |-> !o_analog_en; endproperty
   a_reply_silent: assert property (p_reply_silent)
      else $error("analog output on during reply");
   property p_off_held; $fell(o_analog_en) |-> !o_analog_en [*8]; endproperty
   a_off_held: assert property (p_off_held)
      else $error("analog output back too early");
   property p_unselected;
      o_analog_en && !(i_prog_valid && i_out_select) |=> o_analog_en;
   endproperty
   a_unselected: assert property (p_unselected)
      else $error("exchange without selected strobe");
   property p_reply_len; $rose(o_resp_oe_n) |-> low_cnt_q == 5'h0E; endproperty
   a_reply_len: assert property (p_reply_len)
      else $error("reply length wrong");
   property p_cfg_write;
      $changed(o_span_select) || $changed(o_lin_tc) || $changed(o_quad_tc)
         |-> !o_analog_en && !$past(o_frozen);
   endproperty
   a_cfg_write: assert property (p_cfg_write)
      else $error("configuration changed outside an exchange");
   property p_trim_guard; $changed(o_trim) |-> $past(i_factory_mode) && !o_analog_en; endproperty
   a_trim_guard: assert property (p_trim_guard)
      else $error("trim changed outside production");
   property p_level_pulse; $changed(o_dac_level) |-> o_dac_valid; endproperty
   a_level_pulse: assert property (p_level_pulse)
      else $error("level changed without valid");
   c_reply: cover property ($rose(o_resp_oe_n));
   c_full: cover property (!o_adc_ready);
   c_freeze: cover property ($rose(o_frozen));
endmodule : hall_dsp_config_path_properties

// ===== prog_master_model.sv
`timescale 1ns/1ps
module prog_master_model (
   input wire logic i_sys_clk,
   input wire logic i_resp_bit,
   input wire logic i_resp_oe_n,
   output logic o_prog_valid,
   output logic o_prog_bit
);
   initial
   begin
      o_prog_valid = 1'b0;
      o_prog_bit = 1'b0;
   end
   task automatic xfer(input logic wr, input logic [3:0] addr, input logic [13:0] data,
         output logic [13:0] reply, output logic ok);
      logic [18:0] bits;
      int n;
      int got;
      bits = {wr, addr, data};
      n = wr ? 19 : 5;
      got = 0;
      reply = 14'h0000;
      for (int i = 0; i < n; i++)
      begin
         @(posedge i_sys_clk);
         o_prog_valid <= 1'b1;
         o_prog_bit <= bits[18-i];
      end
      @(posedge i_sys_clk);
      o_prog_valid <= 1'b0;
      o_prog_bit <= ~o_prog_bit;
      // A silent device never drives the pin, so the wait is bounded
      // Sampled mid-cycle: the pin settles only after the edge that launches each bit
      for (int c = 0; c < 40 && got < 14; c++)
      begin
         @(negedge i_sys_clk);
         if (i_resp_oe_n === 1'b0)
         begin
            reply = {reply[12:0], i_resp_bit};
            got++;
         end
      end
      ok = (got == 14);
      @(posedge i_sys_clk);
   endtask : xfer
endmodule : prog_master_model

// ===== tb_hall_dsp_config_path.sv
`timescale 1ns/1ps
`include "hall_dsp_defs.svh"
module tb_hall_dsp_config_path;
   logic i_sys_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_adc_valid = 1'b0;
   logic signed [13:0] i_adc_data = 14'sh0000;
   logic i_dac_ready = 1'b1;
   logic i_out_select = 1'b1;
   logic i_factory_mode = 1'b0;
   logic prog_valid, prog_bit, o_adc_ready, o_dac_valid, o_analog_en;
   logic o_resp_bit, o_resp_oe_n, o_frozen, ok;
   logic [10:0] o_dac_level;
   logic [2:0] o_span_select;
   logic [9:0] o_lin_tc;
   logic [7:0] o_quad_tc;
   logic [23:0] o_trim;
   logic [13:0] rd;
   int err_count = 0;
   int n_checks = 0;
   always #20 i_sys_clk = ~i_sys_clk;
   hall_dsp_config_path i_hall_dsp_config_path (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
      .i_adc_valid(i_adc_valid), .i_adc_data(i_adc_data), .o_adc_ready(o_adc_ready),
      .i_dac_ready(i_dac_ready), .o_dac_valid(o_dac_valid), .o_dac_level(o_dac_level),
      .o_analog_en(o_analog_en), .i_prog_valid(prog_valid), .i_prog_bit(prog_bit),
      .i_out_select(i_out_select), .i_factory_mode(i_factory_mode),
      .o_resp_bit(o_resp_bit), .o_resp_oe_n(o_resp_oe_n), .o_span_select(o_span_select),
      .o_lin_tc(o_lin_tc), .o_quad_tc(o_quad_tc), .o_trim(o_trim), .o_frozen(o_frozen));
   prog_master_model i_prog_master_model (.i_sys_clk(i_sys_clk), .i_resp_bit(o_resp_bit),
      .i_resp_oe_n(o_resp_oe_n), .o_prog_valid(prog_valid), .o_prog_bit(prog_bit));
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic cmd(input logic wr, input logic [3:0] a, input logic [13:0] d,
         input logic exp_ok);
      i_prog_master_model.xfer(wr, a, d, rd, ok);
      chk("reply present", {15'h0000, exp_ok}, {15'h0000, ok});
      if (exp_ok && !ok)
         finish_test;
   endtask : cmd
   task automatic feed(input logic signed [13:0] x, input int n);
      i_adc_data <= x;
      i_adc_valid <= 1'b1;
      i_dac_ready <= 1'b1;
      repeat (n) @(posedge i_sys_clk);
      i_adc_valid <= 1'b0;
      repeat (8) @(posedge i_sys_clk);
   endtask : feed
   task automatic t_config;
      logic [13:0] d;
      for (int c = 0; c < 8; c++)
      begin
         d = 14'((c % 5) * 8 + c);
         cmd(1'b1, `ADDR_FIELD_CONFIG, d, 1'b1);
         chk("echo", {2'h0, d}, {2'h0, rd});
         chk("span", 16'(c), {13'h0000, o_span_select});
         cmd(1'b0, `ADDR_FIELD_CONFIG, 14'h0000, 1'b1);
         chk("field_config", {2'h0, d}, {2'h0, rd});
      end
      cmd(1'b1, `ADDR_LIN_TC, 14'h02A5, 1'b1);
      cmd(1'b1, `ADDR_QUAD_TC, 14'h005A, 1'b1);
      chk("lin_tc", 16'h02A5, {6'h00, o_lin_tc});
      chk("quad_tc", 16'h005A, {8'h00, o_quad_tc});
      $display("t_config done");
   endtask : t_config
   task automatic t_trim_select;
      cmd(1'b1, `ADDR_TRIM_OSC, 14'h00A5, 1'b1);
      chk("trim locked", 16'h0000, o_trim[15:0]);
      i_factory_mode <= 1'b1;
      cmd(1'b1, `ADDR_TRIM_ADC, 14'h003C, 1'b1);
      chk("trim factory", 16'h3C00, o_trim[15:0]);
      i_factory_mode <= 1'b0;
      cmd(1'b1, `ADDR_TRIM_ADC, 14'h0011, 1'b1);
      cmd(1'b0, `ADDR_TRIM_ADC, 14'h0000, 1'b1);
      chk("trim read", 16'h003C, {2'h0, rd});
      i_out_select <= 1'b0;
      cmd(1'b1, `ADDR_LIN_TC, 14'h0111, 1'b0);
      chk("unselected", 16'h02A5, {6'h00, o_lin_tc});
      i_out_select <= 1'b1;
      $display("t_trim_select done");
   endtask : t_trim_select
   task automatic t_path;
      int n;
      cmd(1'b1, `ADDR_FIELD_CONFIG, 14'h0020, 1'b1);
      i_adc_data <= 14'sh20C0;
      i_adc_valid <= 1'b1;
      i_dac_ready <= 1'b0;
      n = 0;
      repeat (40)
      begin
         @(negedge i_sys_clk);
         if (o_adc_ready === 1'b1)
            n++;
         @(posedge i_sys_clk);
      end
      i_adc_valid <= 1'b0;
      chk("fifo words", 16'h0020, 16'(n));
      chk("fifo full", 16'h0000, {15'h0000, o_adc_ready});
      i_dac_ready <= 1'b1;
      n = 0;
      repeat (50)
      begin
         @(negedge i_sys_clk);
         if (o_dac_valid === 1'b1)
            n++;
         @(posedge i_sys_clk);
      end
      chk("level pulses", 16'h0020, 16'(n));
      cmd(1'b0, `ADDR_RAW, 14'h0000, 1'b1);
      chk("raw south", 16'h3A18, {2'h0, rd});
      chk("low clamp", 16'h0000, {5'h00, o_dac_level});
      feed(14'sh1F40, 40);
      cmd(1'b0, `ADDR_RAW, 14'h0000, 1'b1);
      chk("raw north", 16'h05E7, {2'h0, rd});
      chk("high clamp", 16'h07FF, {5'h00, o_dac_level});
      cmd(1'b1, `ADDR_GAIN, 14'h0400, 1'b1);
      feed(14'sh1F40, 4);
      chk("half gain", 16'h06F3, {5'h00, o_dac_level});
      cmd(1'b1, `ADDR_ZERO_LEVEL, 14'h0155, 1'b1);
      feed(14'sh0000, 60);
      cmd(1'b0, `ADDR_RAW, 14'h0000, 1'b1);
      chk("raw zero", 16'h0000, {2'h0, rd});
      chk("zero level", 16'h02AA, {5'h00, o_dac_level});
      cmd(1'b1, `ADDR_CLAMP_LOW, 14'h0300, 1'b1);
      feed(14'sh0000, 4);
      chk("clamp low", 16'h0300, {5'h00, o_dac_level});
      cmd(1'b1, `ADDR_CLAMP_LOW, 14'h0000, 1'b1);
      cmd(1'b1, `ADDR_CLAMP_HIGH, 14'h0200, 1'b1);
      cmd(1'b0, `ADDR_CLAMP_HIGH, 14'h0000, 1'b1);
      chk("clamp_high", 16'h0200, {2'h0, rd});
      feed(14'sh0000, 4);
      chk("clamp high", 16'h0200, {5'h00, o_dac_level});
      $display("t_path done");
   endtask : t_path
   task automatic t_freeze;
      cmd(1'b1, `ADDR_FREEZE, 14'h0001, 1'b1);
      chk("frozen", 16'h0001, {15'h0000, o_frozen});
      cmd(1'b0, `ADDR_RAW, 14'h0000, 1'b0);
      cmd(1'b1, `ADDR_LIN_TC, 14'h0003, 1'b0);
      chk("lin_tc kept", 16'h02A5, {6'h00, o_lin_tc});
      chk("analog on", 16'h0001, {15'h0000, o_analog_en});
      $display("t_freeze done");
   endtask : t_freeze
   initial
   begin
      repeat (5) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      @(posedge i_sys_clk);
      chk("reset state", 16'h0003, {13'h0000, o_frozen, o_analog_en, o_resp_oe_n});
      t_config;
      t_trim_select;
      t_path;
      t_freeze;
      finish_test;
   end
   initial
   begin
      repeat (60000) @(posedge i_sys_clk);
      err_count++;
      $display("[FAIL] run expected done seen hang");
      finish_test;
   end
endmodule : tb_hall_dsp_config_path
bind hall_dsp_config_path hall_dsp_config_path_properties i_props (.i_sys_clk(i_sys_clk),
   .i_rst_n(i_rst_n), .i_prog_valid(i_prog_valid), .i_out_select(i_out_select),
   .i_factory_mode(i_factory_mode), .o_adc_ready(o_adc_ready), .o_dac_level(o_dac_level),
   .o_dac_valid(o_dac_valid), .o_analog_en(o_analog_en), .o_resp_oe_n(o_resp_oe_n),
   .o_span_select(o_span_select), .o_lin_tc(o_lin_tc), .o_quad_tc(o_quad_tc),
   .o_trim(o_trim), .o_frozen(o_frozen));
